// ---- dvt_pkg.sv ----
// constants and carrier types for the duty-coded voltage transition tracker
package dvt_pkg;
    // ==========================================================
    // register command codes
    localparam logic [7:0] DVT_ADDR_UP_COMP = 8'hAF;
    localparam logic [7:0] DVT_ADDR_MAX_DUTY = 8'hB0;
    localparam logic [7:0] DVT_ADDR_FLTR1 = 8'hB1;
    // ==========================================================
    // reset values
    localparam logic [15:0] DVT_UP_COMP_RST = 16'h0000;
    localparam logic [15:0] DVT_MAX_DUTY_RST = 16'h0000;
    localparam logic [15:0] DVT_FLTR1_RST = 16'h0000;
    // ==========================================================
    // timing
    localparam int DVT_CLK_PERIOD_PS = 5000;
    localparam int DVT_FULL_DUTY_LSB_PS = 10000;
    localparam int DVT_FULL_DUTY_CYC = DVT_FULL_DUTY_LSB_PS / DVT_CLK_PERIOD_PS;
    localparam int DVT_RESYNC_LSB_US = 100;
    localparam int DVT_RESYNC_CYC = DVT_RESYNC_LSB_US * 1000000 / DVT_CLK_PERIOD_PS;
    localparam int DVT_GAIN_SHIFT = 9;
    localparam int DVT_HYST_BAND = 1;
    // ==========================================================
    // slow filter window lengths
    localparam logic [11:0] DVT_AVG_512 = 12'h200;
    localparam logic [11:0] DVT_AVG_1024 = 12'h400;
    localparam logic [11:0] DVT_AVG_2048 = 12'h800;
    localparam logic [11:0] DVT_AVG_4056 = 12'hFD8;
    // ==========================================================
    // register layouts
    typedef struct packed {
        logic [10:0] upward_step_compensation;
        logic upward_step_compensation_enable;
        logic [3:0] rise_end_threshold;
    } dvt_up_comp_t;
    typedef struct packed {
        logic [5:0] rsvd;
        logic [8:0] full_duty_on_time_limit;
        logic stuck_level_detect_enable;
    } dvt_max_duty_t;
    typedef struct packed {
        logic [2:0] fall_start_threshold;
        logic [2:0] rise_start_threshold;
        logic [2:0] fall_end_threshold;
        logic [4:0] slow_filter_resync_time;
        logic [1:0] slow_filter_average_window;
    } dvt_fltr1_t;
    typedef enum logic [1:0] {ST_SETTLED, ST_RISE, ST_FALL} dvt_state_t;
endpackage

// ---- dvt_tracker.sv ----
// duty-coded voltage request decoder with transition tracking
`timescale 1ns/1ps
module dvt_tracker #(
    parameter int ON_W = 12,
    parameter int CODE_W = 12,
    parameter int RESYNC_STEP = dvt_pkg::DVT_RESYNC_CYC,
    parameter int STUCK_CYC = 100000
) (
    input wire logic mclk_i,
    input wire logic reset_i,
    input wire logic duty_coded_voltage_request_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic [10:0] gain_i,
    input wire logic [CODE_W-1:0] minimum_output_code_i,
    input wire logic transition_trigger_select_i,
    input wire logic slow_filter_resync_enable_i,
    input wire logic [2:0] ton_rise_threshold_i,
    input wire logic [2:0] ton_fall_threshold_i,
    output logic [15:0] reg_rdata_o,
    output logic [CODE_W-1:0] output_reference_o,
    output logic [CODE_W-1:0] requested_voltage_code_o,
    output logic rise_active_o,
    output logic fall_active_o,
    output logic full_duty_o,
    output logic stuck_high_o,
    output logic stuck_low_o
);
    import dvt_pkg::*;

    // ==========================================================
    // register file
    dvt_up_comp_t upc_r, upc_nxt;
    dvt_max_duty_t mxd_r, mxd_nxt;
    dvt_fltr1_t flt_r, flt_nxt;
    logic [15:0] rd_r, rd_nxt;

    // write decode and read mux
    always_comb begin
        upc_nxt = upc_r;
        mxd_nxt = mxd_r;
        flt_nxt = flt_r;
        if (reg_wr_i && reg_addr_i == DVT_ADDR_UP_COMP) begin
            upc_nxt = reg_wdata_i;
        end
        if (reg_wr_i && reg_addr_i == DVT_ADDR_MAX_DUTY) begin
            mxd_nxt = {6'h00, reg_wdata_i[9:0]};
        end
        if (reg_wr_i && reg_addr_i == DVT_ADDR_FLTR1) begin
            flt_nxt = reg_wdata_i;
        end
        case (reg_addr_i)
            DVT_ADDR_UP_COMP: rd_nxt = upc_r;
            DVT_ADDR_MAX_DUTY: rd_nxt = mxd_r;
            DVT_ADDR_FLTR1: rd_nxt = flt_r;
            default: rd_nxt = 16'h0000;
        endcase
    end

    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            upc_r <= DVT_UP_COMP_RST;
            mxd_r <= DVT_MAX_DUTY_RST;
            flt_r <= DVT_FLTR1_RST;
            rd_r <= 16'h0000;
        end else begin
            upc_r <= upc_nxt;
            mxd_r <= mxd_nxt;
            flt_r <= flt_nxt;
            rd_r <= rd_nxt;
        end
    end

    // ==========================================================
    // on-time measurement, full duty and stuck level
    logic in_r, in_nxt, samp_r, samp_nxt;
    logic full_r, full_nxt, shi_r, shi_nxt, slo_r, slo_nxt;
    logic [ON_W-1:0] hi_r, hi_nxt, per_cnt_r, per_cnt_nxt;
    logic [ON_W-1:0] on_r, on_nxt, per_r, per_nxt;
    logic [31:0] idle_r, idle_nxt;
    logic edge_rise, edge_fall;
    logic [ON_W:0] lim_cyc;

    assign edge_rise = duty_coded_voltage_request_i & ~in_r;
    assign edge_fall = ~duty_coded_voltage_request_i & in_r;
    assign lim_cyc = (ON_W+1)'(mxd_r.full_duty_on_time_limit * DVT_FULL_DUTY_CYC);

    // counts high time and period, latches them at the edges
    always_comb begin
        in_nxt = duty_coded_voltage_request_i;
        samp_nxt = edge_rise;
        on_nxt = edge_fall ? hi_r : on_r;
        per_nxt = edge_rise ? per_cnt_r : per_r;
        // the rising cycle itself counts as the first high and first period clock
        hi_nxt = hi_r;
        per_cnt_nxt = per_cnt_r;
        if (edge_rise) begin
            hi_nxt = ON_W'(1);
        end else if (duty_coded_voltage_request_i && hi_r != '1) begin
            hi_nxt = hi_r + 1'b1;
        end
        if (edge_rise) begin
            per_cnt_nxt = ON_W'(1);
        end else if (per_cnt_r != '1) begin
            per_cnt_nxt = per_cnt_r + 1'b1;
        end
        full_nxt = full_r;
        if (edge_fall) begin
            full_nxt = {1'b0, hi_r} > lim_cyc;
        end
        idle_nxt = (edge_rise || edge_fall) ? 32'h00000000 : idle_r + 32'h00000001;
        shi_nxt = shi_r & ~(edge_rise | edge_fall);
        slo_nxt = slo_r & ~(edge_rise | edge_fall);
        if (mxd_r.stuck_level_detect_enable && idle_r >= 32'(STUCK_CYC - 1)) begin
            shi_nxt = in_r;
            slo_nxt = ~in_r;
            samp_nxt = 1'b1;
            idle_nxt = 32'h00000000;
        end
        if (!mxd_r.stuck_level_detect_enable) begin
            shi_nxt = 1'b0;
            slo_nxt = 1'b0;
        end
    end

    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            in_r <= 1'b0;
            samp_r <= 1'b0;
            hi_r <= '0;
            per_cnt_r <= '0;
            on_r <= '0;
            per_r <= '0;
            full_r <= 1'b0;
            idle_r <= 32'h00000000;
            shi_r <= 1'b0;
            slo_r <= 1'b0;
        end else begin
            in_r <= in_nxt;
            samp_r <= samp_nxt;
            hi_r <= hi_nxt;
            per_cnt_r <= per_cnt_nxt;
            on_r <= on_nxt;
            per_r <= per_nxt;
            full_r <= full_nxt;
            idle_r <= idle_nxt;
            shi_r <= shi_nxt;
            slo_r <= slo_nxt;
        end
    end

    // ==========================================================
    // target, fast filter, slow averaging filter with hysteresis
    dvt_state_t st_r, st_nxt;
    logic [CODE_W-1:0] tgt_r, tgt_nxt, fast_r, fast_nxt;
    logic [CODE_W-1:0] avg_r, avg_nxt, hyst_r, hyst_nxt;
    logic [ON_W-1:0] prev_r, prev_nxt;
    logic [CODE_W+11:0] acc_r, acc_nxt;
    logic [11:0] cnt_r, cnt_nxt, win;
    logic [19:0] still_r, still_nxt;
    logic [ON_W:0] duty;
    logic [ON_W+11:0] prod;
    logic [CODE_W:0] diff;

    // window length picked by the average select field
    function automatic logic [11:0] win_len(input logic [1:0] sel);
        case (sel)
            2'b00: win_len = DVT_AVG_512;
            2'b01: win_len = DVT_AVG_1024;
            2'b10: win_len = DVT_AVG_2048;
            default: win_len = DVT_AVG_4056;
        endcase
    endfunction

    assign win = win_len(flt_r.slow_filter_average_window);

    always_comb begin
        // a line held low means no duty, whatever the last on-time was
        duty = {1'b0, slo_r ? {ON_W{1'b0}} : ((shi_r | full_r) ? per_r : on_r)};
        if (st_r == ST_RISE && upc_r.upward_step_compensation_enable) begin
            duty = duty + (ON_W+1)'(upc_r.upward_step_compensation);
        end
        prod = {11'h000, duty} * {(ON_W+1)'(0), gain_i};
        tgt_nxt = tgt_r;
        fast_nxt = fast_r;
        prev_nxt = prev_r;
        acc_nxt = acc_r;
        cnt_nxt = cnt_r;
        avg_nxt = avg_r;
        if (samp_r) begin
            tgt_nxt = CODE_W'(prod >> DVT_GAIN_SHIFT) + minimum_output_code_i;
            prev_nxt = on_r;
            fast_nxt = CODE_W'(({1'b0, fast_r} + {1'b0, tgt_nxt}) >> 1);
            acc_nxt = acc_r + (CODE_W+12)'(tgt_nxt);
            cnt_nxt = cnt_r + 12'h001;
            if (cnt_r + 12'h001 >= win) begin
                case (flt_r.slow_filter_average_window)
                    2'b00: avg_nxt = CODE_W'(acc_nxt >> 9);
                    2'b01: avg_nxt = CODE_W'(acc_nxt >> 10);
                    2'b10: avg_nxt = CODE_W'(acc_nxt >> 11);
                    default: avg_nxt = CODE_W'(acc_nxt / DVT_AVG_4056);
                endcase
                acc_nxt = '0;
                cnt_nxt = 12'h000;
            end
        end
        // hysteresis follows moves beyond the band, or any offset once the resync time has run with resync enabled
        diff = (avg_r > hyst_r) ? {1'b0, avg_r - hyst_r} : {1'b0, hyst_r - avg_r};
        hyst_nxt = hyst_r;
        still_nxt = (still_r != 20'hFFFFF) ? still_r + 20'h00001 : still_r;
        if (diff > (CODE_W+1)'(DVT_HYST_BAND)) begin
            hyst_nxt = avg_r;
            still_nxt = 20'h00000;
        end else if (slow_filter_resync_enable_i && hyst_r != avg_r
                     && still_r >= 20'(flt_r.slow_filter_resync_time * RESYNC_STEP)) begin
            hyst_nxt = avg_r;
            still_nxt = 20'h00000;
        end
    end

    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            tgt_r <= '0;
            fast_r <= '0;
            avg_r <= '0;
            hyst_r <= '0;
            prev_r <= '0;
            acc_r <= '0;
            cnt_r <= 12'h000;
            still_r <= 20'h00000;
        end else begin
            tgt_r <= tgt_nxt;
            fast_r <= fast_nxt;
            avg_r <= avg_nxt;
            hyst_r <= hyst_nxt;
            prev_r <= prev_nxt;
            acc_r <= acc_nxt;
            cnt_r <= cnt_nxt;
            still_r <= still_nxt;
        end
    end

    // ==========================================================
    // transition state machine and reference select
    logic [CODE_W-1:0] ref_r, ref_nxt;
    logic rise_r, rise_nxt, fall_r, fall_nxt;
    logic [CODE_W:0] ref_x, tgt_x;

    assign ref_x = {1'b0, ref_r};
    assign tgt_x = {1'b0, tgt_r};

    always_comb begin
        st_nxt = st_r;
        case (st_r)
            ST_SETTLED: begin
                if (!transition_trigger_select_i) begin
                    if (tgt_x > ref_x + flt_r.rise_start_threshold) begin
                        st_nxt = ST_RISE;
                    end else if (tgt_x + flt_r.fall_start_threshold < ref_x) begin
                        st_nxt = ST_FALL;
                    end
                end else if (samp_r) begin
                    if (on_r > prev_r && on_r - prev_r > ON_W'(ton_rise_threshold_i)) begin
                        st_nxt = ST_RISE;
                    end else if (prev_r > on_r && prev_r - on_r > ON_W'(ton_fall_threshold_i)) begin
                        st_nxt = ST_FALL;
                    end
                end
            end
            ST_RISE: begin
                if (ref_x + upc_r.rise_end_threshold > tgt_x) begin
                    st_nxt = ST_SETTLED;
                end
            end
            ST_FALL: begin
                if (ref_x < tgt_x + flt_r.fall_end_threshold) begin
                    st_nxt = ST_SETTLED;
                end
            end
            default: st_nxt = ST_SETTLED;
        endcase
        ref_nxt = (st_nxt == ST_SETTLED) ? hyst_r : fast_r;
        rise_nxt = (st_nxt == ST_RISE);
        fall_nxt = (st_nxt == ST_FALL);
    end

    // reset lands in settled on the slow path
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            st_r <= ST_SETTLED;
            ref_r <= '0;
            rise_r <= 1'b0;
            fall_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            ref_r <= ref_nxt;
            rise_r <= rise_nxt;
            fall_r <= fall_nxt;
        end
    end

    // outputs straight from flip-flops
    assign reg_rdata_o = rd_r;
    assign output_reference_o = ref_r;
    assign requested_voltage_code_o = tgt_r;
    assign rise_active_o = rise_r;
    assign fall_active_o = fall_r;
    assign full_duty_o = full_r;
    assign stuck_high_o = shi_r;
    assign stuck_low_o = slo_r;

    // ==========================================================
    // checks
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (reset_i);

    a_settled_slow_ref: assert property (st_r == ST_SETTLED |-> ref_r == $past(hyst_r))
        else $error("settled reference not from slow filter");
    a_rise_fast_ref: assert property (st_r == ST_RISE |-> ref_r == $past(fast_r))
        else $error("rise reference not from fast filter");
    a_rise_entry: assert property (st_r == ST_SETTLED && !transition_trigger_select_i
        && tgt_x > ref_x + flt_r.rise_start_threshold |=> st_r == ST_RISE)
        else $error("rise not entered");
    a_fall_entry: assert property (st_r == ST_SETTLED && !transition_trigger_select_i
        && tgt_x <= ref_x + flt_r.rise_start_threshold
        && tgt_x + flt_r.fall_start_threshold < ref_x |=> st_r == ST_FALL)
        else $error("fall not entered");
    a_rise_exit: assert property (st_r == ST_RISE
        && ref_x + upc_r.rise_end_threshold > tgt_x |=> st_r == ST_SETTLED)
        else $error("rise not ended");
    a_fall_exit: assert property (st_r == ST_FALL
        && ref_x < tgt_x + flt_r.fall_end_threshold |=> st_r == ST_SETTLED)
        else $error("fall not ended");
    a_rsvd_read_zero: assert property (reg_addr_i == DVT_ADDR_MAX_DUTY
        |=> reg_rdata_o[15:10] == 6'h00)
        else $error("reserved bits read nonzero");
    a_full_duty_flag: assert property (edge_fall && {1'b0, hi_r} > lim_cyc
        |=> full_duty_o)
        else $error("full duty not flagged");
    a_stuck_disabled: assert property (!mxd_r.stuck_level_detect_enable
        |=> !stuck_high_o && !stuck_low_o)
        else $error("stuck flag while disabled");
    a_resync_force: assert property (slow_filter_resync_enable_i && hyst_r != avg_r
        && still_r >= 20'(flt_r.slow_filter_resync_time * RESYNC_STEP) |=> hyst_r == $past(avg_r))
        else $error("hysteresis not resynced");
    a_window_bound: assert property (samp_r && cnt_r + 12'h001 >= win
        |=> cnt_r == 12'h000)
        else $error("averaging window overrun");
endmodule // dvt_tracker

// ---- dvt_host_model.sv ----
// host model that drives the duty-coded voltage request line
`timescale 1ns/1ps
module dvt_host_model (
    input wire logic mclk_i,
    input wire logic [7:0] high_cyc_i,
    input wire logic [7:0] low_cyc_i,
    input wire logic [1:0] hold_i,
    output logic duty_coded_voltage_request_o
);
    // ==========================================================
    // waveform generator
    int cnt;
    // start low so the first period begins on a clean rising edge
    initial begin
        cnt = 0;
        duty_coded_voltage_request_o = 1'b0;
    end
    // high for high_cyc_i clocks then low for low_cyc_i clocks, or a held level
    always @(posedge mclk_i) begin
        if (hold_i == 2'h1) begin
            duty_coded_voltage_request_o <= 1'b1;
            cnt <= 0;
        end else if (hold_i == 2'h2) begin
            duty_coded_voltage_request_o <= 1'b0;
            cnt <= 0;
        end else begin
            // a shortened period restarts at once instead of running on
            if (cnt >= int'(high_cyc_i) + int'(low_cyc_i) - 1) begin
                cnt <= 0;
            end else begin
                cnt <= cnt + 1;
            end
            duty_coded_voltage_request_o <= (cnt < int'(high_cyc_i));
        end
    end
endmodule // dvt_host_model

// ---- tb_top.sv ----
// self-checking testbench for the duty-coded voltage transition tracker
`timescale 1ns/1ps
module tb_top;
    import dvt_pkg::*;
    typedef struct {int sel; logic [15:0] exp;} dvt_note_t;
    // ==========================================================
    // stimulus and observation signals
    logic clk = 1'b0, rst = 1'b1, wr = 1'b0, look = 1'b0, trig = 1'b0, sync = 1'b1;
    logic pwm;
    logic [7:0] addr = 8'h00, hi = 8'h08, lo = 8'h08;
    logic [1:0] hold = 2'h0;
    logic [15:0] wdata = 16'h0000, rdata, rv;
    logic [10:0] gain = 11'h200;
    logic [11:0] minc = 12'h000, ref_code, code;
    logic [2:0] tonr = 3'h3, tonf = 3'h3;
    logic rise, fall, full, sh, sl;
    int fail_count = 0, check_count = 0, cyc = 0, h, l, g, m;
    dvt_note_t notes[$];
    dvt_note_t cur;
    string nm[8] = '{"reg_rdata_o", "requested_voltage_code_o", "full_duty_o", "stuck_high_o",
                     "stuck_low_o", "rise_active_o", "fall_active_o", "output_reference_o"};
    // 200 MHz clock
    always #2.5 clk = ~clk;
    dvt_host_model host (.mclk_i(clk), .high_cyc_i(hi), .low_cyc_i(lo), .hold_i(hold),
                         .duty_coded_voltage_request_o(pwm));
    // short resync step and stuck time keep the run brief
    dvt_tracker #(.RESYNC_STEP(20), .STUCK_CYC(50)) DUT (
        .mclk_i(clk), .reset_i(rst), .duty_coded_voltage_request_i(pwm),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .gain_i(gain),
        .minimum_output_code_i(minc), .transition_trigger_select_i(trig),
        .slow_filter_resync_enable_i(sync), .ton_rise_threshold_i(tonr),
        .ton_fall_threshold_i(tonf), .reg_rdata_o(rdata), .output_reference_o(ref_code),
        .requested_voltage_code_o(code), .rise_active_o(rise), .fall_active_o(fall),
        .full_duty_o(full), .stuck_high_o(sh), .stuck_low_o(sl));
    // ==========================================================
    // observation helpers
    function automatic logic [15:0] seen(input int sel);
        case (sel)
            0: seen = rdata;
            1: seen = {4'h0, code};
            2: seen = {15'h0000, full};
            3: seen = {15'h0000, sh};
            4: seen = {15'h0000, sl};
            5: seen = {15'h0000, rise};
            6: seen = {15'h0000, fall};
            default: seen = {4'h0, ref_code};
        endcase
    endfunction
    // checker: takes the oldest note whenever the driver flags a result
    always @(negedge clk) begin
        if (look) begin
            check_count++;
            if (notes.size() == 0) begin
                fail_count++;
                $display("BAD note queue empty");
            end else begin
                cur = notes.pop_front();
                if (seen(cur.sel) !== cur.exp) begin
                    fail_count++;
                    $display("BAD %s expected %h seen %h", nm[cur.sel], cur.exp, seen(cur.sel));
                end
            end
        end
    end
    // ==========================================================
    // driver tasks
    task automatic results();
        if (fail_count == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic expect_now(input int sel, input logic [15:0] e);
        notes.push_back('{sel, e});
        @(posedge clk);
        look <= 1'b1;
        @(posedge clk);
        look <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [15:0] e);
        @(posedge clk);
        addr <= a;
        repeat (3) @(posedge clk);
        expect_now(0, e);
    endtask
    task automatic wave(input int ht, input int lt, input int hd, input int cycles);
        @(posedge clk);
        hi <= 8'(ht);
        lo <= 8'(lt);
        hold <= 2'(hd);
        repeat (cycles) @(posedge clk);
    endtask
    task automatic wait_for(input int sel, input logic [15:0] v, input int lim);
        for (int i = 0; i < lim && seen(sel) !== v; i++) @(posedge clk);
    endtask
    // cut a hang short
    always @(posedge clk) begin
        cyc++;
        if (cyc == 30000) begin
            fail_count++;
            results();
        end
    end
    // ==========================================================
    // main sequence
    initial begin
        void'($urandom(32'hD58F));
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rd_reg(DVT_ADDR_UP_COMP, DVT_UP_COMP_RST);
        rd_reg(DVT_ADDR_MAX_DUTY, DVT_MAX_DUTY_RST);
        rd_reg(DVT_ADDR_FLTR1, DVT_FLTR1_RST);
        wr_reg(DVT_ADDR_MAX_DUTY, 16'hFFFF);
        rd_reg(DVT_ADDR_MAX_DUTY, 16'h03FF);
        wr_reg(8'hA0, 16'hFFFF);
        rd_reg(8'hA0, 16'h0000);
        // random words read back whole from the plain read-write registers
        for (int i = 0; i < 4; i++) begin
            rv = 16'($urandom);
            wr_reg((i % 2 == 0) ? DVT_ADDR_UP_COMP : DVT_ADDR_FLTR1, rv);
            rd_reg((i % 2 == 0) ? DVT_ADDR_UP_COMP : DVT_ADDR_FLTR1, rv);
        end
        wr_reg(DVT_ADDR_UP_COMP, 16'h0000);
        wr_reg(DVT_ADDR_MAX_DUTY, 16'h01FE);
        // random on-times, gains and minimum codes through the target formula
        for (int i = 0; i < 5; i++) begin
            h = 1 + $urandom % 12;
            l = 4 + $urandom % 12;
            g = 512 << ($urandom % 2);
            m = $urandom % 256;
            gain <= 11'(g);
            minc <= 12'(m);
            wave(h, l, 0, 4 * (h + l) + 8);
            expect_now(1, 16'(((h * g) >> 9) + m));
        end
        gain <= 11'h200;
        minc <= 12'h007;
        wr_reg(DVT_ADDR_MAX_DUTY, 16'h0009);
        wave(10, 6, 0, 72);
        expect_now(2, 16'h0001);
        expect_now(1, 16'h0017);
        wave(8, 8, 0, 72);
        expect_now(2, 16'h0000);
        expect_now(1, 16'h000F);
        wave(8, 8, 1, 80);
        expect_now(3, 16'h0001);
        wave(8, 8, 2, 80);
        expect_now(4, 16'h0001);
        expect_now(1, 16'h0007);
        wave(8, 8, 0, 40);
        wr_reg(DVT_ADDR_MAX_DUTY, 16'h0008);
        wave(8, 8, 1, 80);
        expect_now(3, 16'h0000);
        // second reset in mid-run
        rst <= 1'b1;
        minc <= 12'h000;
        expect_now(7, 16'h0000);
        expect_now(5, 16'h0000);
        rst <= 1'b0;
        wr_reg(DVT_ADDR_MAX_DUTY, 16'h01FE);
        // start thresholds kept above end thresholds; comp 3 codes for a step of 1
        wr_reg(DVT_ADDR_FLTR1, 16'h6C84);
        wr_reg(DVT_ADDR_UP_COMP, 16'h0072);
        wave(20, 12, 0, 0);
        wait_for(5, 16'h0001, 200);
        expect_now(5, 16'h0001);
        expect_now(6, 16'h0000);
        repeat (36) @(posedge clk);
        expect_now(1, 16'h0017);
        // on-time mode keeps the slow path after the rise ends
        trig <= 1'b1;
        wait_for(5, 16'h0000, 600);
        expect_now(5, 16'h0000);
        // on-time mode: a large on-time drop starts a fall
        wr_reg(DVT_ADDR_UP_COMP, 16'h0002);
        trig <= 1'b1;
        wait_for(5, 16'h0000, 600);
        wave(4, 28, 0, 0);
        wait_for(6, 16'h0001, 200);
        expect_now(6, 16'h0001);
        wait_for(6, 16'h0000, 800);
        expect_now(6, 16'h0000);
        expect_now(1, 16'h0004);
        results();
    end
endmodule // tb_top
